// *** design/charge_ctrl.sv ***
// Function
// (RULE1) Sense at or above 4 V ends fast charge, moves straight to trickle.
// (RULE2) Sense at 5 V reset level resets everything; reinsertion restarts charging.
// (RULE3) Converter is five-bit coarse plus five-bit fine linear count, 6.5 mV steps.
// (RULE4) One measurement per 20.48 s cycle inside a 2.56 s currentless break.
// (RULE5) Break holds 1.28 s settling, then the 1.28 s measurement phase.
// (RULE6) Sync output pulses 10 ms, starting 40 ms into each break.
// (RULE7) Flag a drop when new value is 12 mV below stored value.
// (RULE8) Drop terminates only after three consecutive measurement cycles.
// (RULE9) Four-bit up/down slope counter steps once per fine conversion.
// (RULE10) Slope counter counts up eight cycles then down eight cycles.
// (RULE11) Net count above two LSB after sixteen cycles ends normal charge.
// (RULE12) Second slope counter offset by eight cycles gives decisions every eight.
// (RULE13) No charging with temperature outside window or faulty sensor.
// (RULE14) Over-temperature through a whole cycle switches off permanently with failure shown.
// (RULE15) Indicators per state: none, fast blink, top-off, trickle, failure blink.
// (RULE16) Failure on bad temperature even without battery, or sense below 0.1 V; with no battery the failure blink stays dark.
// (RULE17) Blinking indicators toggle at oscillator frequency over 1024.
// (RULE18) Slope termination suppressed for the first five minutes of fast charge.
// (RULE19) After slope termination, 5.12 s pulses per 20.48 s for 20 minutes.
// (RULE20) Then trickle: one 5.12 s pulse per 1310.72 s until removal.
// (RULE21) Below 1.6 V preform with trickle blinking; failure blink after 10 minutes.
// (RULE22) All timings count oscillator periods; 20.48 s is 16384 periods.
`timescale 1ns/100ps
`default_nettype none
module charge_ctrl #(
  parameter int OSC_DIV = charge_pkg::OSC_DIV
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable,
  // Comparator levels
  input wire charge_pkg::sense_s sense,
  // Charge control
  output logic charge_on,
  output logic break_sync,
  output logic [charge_pkg::CODE_W-1:0] dac_code,
  // Status indicators
  output charge_pkg::ind_s ind
);
  localparam int TW = charge_pkg::TICK_W;
  localparam int CW = charge_pkg::CYC_W;
  localparam int DW = charge_pkg::CODE_W;
  localparam int FW = charge_pkg::FINE_W;
  localparam int SW = charge_pkg::SLOPE_W;

  typedef struct packed {
    charge_pkg::mode_e mode;
    charge_pkg::conv_e conv;
    logic [TW-1:0] tick;
    logic [CW-1:0] cyc;
    logic [CW-1:0] stage_cyc;
    logic [DW-1:0] code;
    logic [DW-1:0] prev;
    logic [DW-1:0] peak;
    logic [1:0] ndv_cnt;
    logic have_ref;
    logic meas_done;
    logic temp_bad;
    logic perm_off;
    logic late;
    logic charge_on;
    logic sync;
    charge_pkg::ind_s ind;
  } st_s;

  st_s st_q;
  st_s st_d;
  logic osc_tick;
  logic healthy;
  logic ndv_hit;
  logic slope_ok;
  logic slope_step;
  logic slope_clear;
  logic signed [SW-1:0] delta;
  logic [1:0] slope_det;

  function automatic logic in_range(input logic [TW-1:0] t, input int lo, input int hi);
    return (t >= TW'(lo)) && (t < TW'(hi));
  endfunction : in_range

  function automatic logic is_charging(input charge_pkg::mode_e m);
    return m inside {charge_pkg::PREFORM, charge_pkg::FAST, charge_pkg::TOPOFF, charge_pkg::TRICKLE};
  endfunction : is_charging

  osc_tick_gen #(
    .DIV(OSC_DIV)
  ) u_osc (
    .clock(clock),
    .rst_n(rst_n),
    .enable(enable),
    .tick(osc_tick)
  );

  // Two counters half a window apart halve the worst-case termination delay
  for (genvar i = 0; i < 2; i++) begin : g_slope
    slope_counter #(
      .START(SW'(i * charge_pkg::SLOPE_HALF))
    ) u_slope (
      .clock(clock),
      .rst_n(rst_n),
      .enable(enable),
      .clear(slope_clear),
      .step(slope_step),
      .delta(delta),
      .detect(slope_det[i])
    ); // see (RULE12)
  end

  always_comb begin
    logic signed [DW:0] diff;
    diff = $signed({1'b0, st_q.code}) - $signed({1'b0, st_q.prev});
    if (diff > (DW+1)'(2**(SW-1) - 1)) begin
      delta = SW'(2**(SW-1) - 1);
    end else if (diff < -(DW+1)'(2**(SW-1))) begin
      delta = SW'(-(2**(SW-1)));
    end else begin
      delta = diff[SW-1:0];
    end
  end

  assign healthy = !sense.removed && sense.temp_ok && !sense.sensor_fault && !sense.batt_low;
  // One extra bit keeps a code near full scale from wrapping into a false drop
  assign ndv_hit = st_q.have_ref
    && ({1'b0, st_q.code} + (DW+1)'(charge_pkg::NDV_LSB) <= {1'b0, st_q.peak}); // see (RULE7)
  assign slope_step = st_q.meas_done && st_q.mode == charge_pkg::FAST && st_q.have_ref; // see (RULE9)
  assign slope_clear = st_q.mode != charge_pkg::FAST;
  assign slope_ok = (|slope_det) && st_q.stage_cyc >= CW'(charge_pkg::SLOPE_HOLD_CYC); // see (RULE18)

  always_comb begin
    logic wrap;
    logic blink;
    wrap = 1'b0;
    blink = 1'b0;
    st_d = st_q;
    st_d.meas_done = 1'b0;
    // Cycle timebase on oscillator periods
    if (osc_tick) begin // see (RULE22)
      st_d.tick = st_q.tick + TW'(1);
      wrap = st_q.tick == TW'(charge_pkg::CYCLE_T - 1);
      if (wrap) begin
        st_d.cyc = st_q.cyc + CW'(1);
        if (st_q.stage_cyc != '1) begin
          st_d.stage_cyc = st_q.stage_cyc + CW'(1);
        end
      end
      // Linear-count conversion, coarse steps then fine steps
      unique case (st_q.conv)
        charge_pkg::CONV_IDLE: begin
          if (st_q.tick == TW'(charge_pkg::SETTLE_T)) begin // see (RULE5)
            st_d.conv = charge_pkg::CONV_COARSE;
            st_d.code = '0;
          end
        end
        charge_pkg::CONV_COARSE: begin // see (RULE3)
          if (sense.dac_above) begin
            if (st_q.code[DW-1:FW] != '0) begin
              st_d.code = st_q.code - DW'(2**FW);
            end
            st_d.conv = charge_pkg::CONV_FINE;
          end else if (st_q.code[DW-1:FW] == '1) begin
            st_d.conv = charge_pkg::CONV_FINE;
          end else begin
            st_d.code = st_q.code + DW'(2**FW);
          end
        end
        charge_pkg::CONV_FINE: begin
          if (sense.dac_above || st_q.code[FW-1:0] == '1) begin
            if (sense.dac_above && st_q.code[FW-1:0] != '0) begin
              st_d.code = st_q.code - DW'(1);
            end
            st_d.conv = charge_pkg::CONV_IDLE;
            st_d.meas_done = 1'b1;
          end else begin
            st_d.code = st_q.code + DW'(1);
          end
        end
        default: st_d.conv = charge_pkg::CONV_IDLE;
      endcase
    end
    // Drop and slope evaluation once per finished conversion
    if (st_q.meas_done && st_q.mode == charge_pkg::FAST) begin
      st_d.prev = st_q.code;
      if (!st_q.have_ref) begin
        st_d.have_ref = 1'b1;
        st_d.peak = st_q.code;
      end else if (ndv_hit) begin
        st_d.ndv_cnt = st_q.ndv_cnt + 2'h1; // see (RULE8)
      end else begin
        st_d.ndv_cnt = '0;
        if (st_q.code > st_q.peak) begin
          st_d.peak = st_q.code;
        end
      end
    end
    // Temperature must stay bad across a full cycle before it latches
    if (wrap) begin
      st_d.temp_bad = !sense.temp_ok;
      if (st_q.temp_bad && !sense.temp_ok && st_q.mode == charge_pkg::FAILED) begin
        st_d.perm_off = 1'b1; // see (RULE14)
      end
    end
    // Mode sequencing
    unique case (st_q.mode)
      charge_pkg::NO_BATT: begin
        if (!sense.removed) begin
          st_d.stage_cyc = '0;
          st_d.cyc = '0;
          st_d.mode = sense.below_preform ? charge_pkg::PREFORM : charge_pkg::FAST; // see (RULE21)
        end
      end
      charge_pkg::PREFORM: begin
        if (st_q.stage_cyc >= CW'(charge_pkg::PREFORM_CYC)) begin
          st_d.late = 1'b1; // see (RULE21)
        end
        if (sense.overload) begin
          st_d.mode = charge_pkg::TRICKLE;
        end else if (!sense.below_preform) begin
          st_d.mode = charge_pkg::FAST;
          st_d.stage_cyc = '0;
          st_d.late = 1'b0;
        end
      end
      charge_pkg::FAST: begin
        if (sense.overload) begin
          st_d.mode = charge_pkg::TRICKLE; // see (RULE1)
        end else if (st_q.meas_done && ndv_hit && st_q.ndv_cnt == 2'(charge_pkg::NDV_REPEAT - 1)) begin
          st_d.mode = charge_pkg::TRICKLE; // see (RULE8)
        end else if (slope_ok) begin
          st_d.mode = charge_pkg::TOPOFF; // see (RULE11)
          st_d.stage_cyc = '0;
        end
      end
      charge_pkg::TOPOFF: begin
        if (st_q.stage_cyc >= CW'(charge_pkg::TOPOFF_CYC)) begin
          st_d.mode = charge_pkg::TRICKLE; // see (RULE19)
        end
      end
      charge_pkg::TRICKLE: st_d.mode = charge_pkg::TRICKLE; // see (RULE20)
      charge_pkg::FAILED: begin
        if (sense.temp_ok && !sense.sensor_fault && !sense.batt_low && !st_q.perm_off) begin
          st_d.mode = charge_pkg::NO_BATT; // see (RULE14)
        end
      end
      default: st_d.mode = charge_pkg::FAILED;
    endcase
    if (!sense.temp_ok || sense.sensor_fault) begin
      st_d.mode = charge_pkg::FAILED; // see (RULE13)
    end else if (sense.batt_low && is_charging(st_q.mode)) begin
      st_d.mode = charge_pkg::FAILED; // see (RULE16)
    end
    // Removal clears every function; bad temperature selects failed mode, though the zeroed timebase keeps its blink dark
    if (sense.removed) begin // see (RULE2)
      st_d = '0;
      st_d.mode = sense.temp_ok && !sense.sensor_fault ? charge_pkg::NO_BATT : charge_pkg::FAILED; // see (RULE16)
    end
    if (st_d.mode != charge_pkg::FAST) begin
      st_d.have_ref = 1'b0;
      st_d.ndv_cnt = '0;
    end
    // Outputs registered from the next state
    blink = st_d.tick[charge_pkg::BLINK_BIT]; // see (RULE17)
    st_d.sync = in_range(st_d.tick, charge_pkg::SYNC_DELAY_T, charge_pkg::SYNC_END_T); // see (RULE6)
    unique case (st_d.mode)
      charge_pkg::FAST: st_d.charge_on = st_d.tick >= TW'(charge_pkg::BREAK_T); // see (RULE4)
      charge_pkg::TOPOFF: st_d.charge_on = in_range(st_d.tick, charge_pkg::BREAK_T, charge_pkg::PULSE_END_T);
      charge_pkg::TRICKLE: begin
        st_d.charge_on = st_d.cyc == '0 && in_range(st_d.tick, charge_pkg::BREAK_T, charge_pkg::PULSE_END_T);
      end
      default: st_d.charge_on = 1'b0;
    endcase
    st_d.ind.failure_indicator = blink && (st_d.mode == charge_pkg::FAILED || st_d.mode == charge_pkg::PREFORM && st_d.late);
    st_d.ind.trickle_indicator = st_d.mode inside {charge_pkg::TOPOFF, charge_pkg::TRICKLE}
      || blink && st_d.mode == charge_pkg::PREFORM && !st_d.late; // see (RULE15)
    st_d.ind.fast_charge_indicator = blink && st_d.mode == charge_pkg::FAST;
    st_d.ind.topoff_indicator = st_d.mode == charge_pkg::TOPOFF;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else if (enable) begin
      st_q <= st_d;
    end
  end

  assign charge_on = st_q.charge_on;
  assign break_sync = st_q.sync;
  assign dac_code = st_q.code;
  assign ind = st_q.ind;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n || !enable);

  sequence s_ndv_third;
    st_q.mode == charge_pkg::FAST && st_q.meas_done && ndv_hit && st_q.ndv_cnt == 2'(charge_pkg::NDV_REPEAT - 1)
      && healthy;
  endsequence

  sequence s_ndv_early;
    st_q.mode == charge_pkg::FAST && st_q.meas_done && ndv_hit && st_q.ndv_cnt < 2'(charge_pkg::NDV_REPEAT - 1)
      && healthy
      && !sense.overload && !slope_ok;
  endsequence

  a_removal_reset: assert property (sense.removed && sense.temp_ok && !sense.sensor_fault // see (RULE2)
    |=> st_q.mode == charge_pkg::NO_BATT && !st_q.charge_on) else $error("removal did not reset");
  a_overload_trickle: assert property (st_q.mode == charge_pkg::FAST && sense.overload && healthy // see (RULE1)
    |=> st_q.mode == charge_pkg::TRICKLE) else $error("overload did not go to trickle");
  a_ndv_end: assert property (s_ndv_third |=> st_q.mode == charge_pkg::TRICKLE) // see (RULE8)
    else $error("third drop did not terminate");
  a_ndv_wait: assert property (s_ndv_early |=> st_q.mode == charge_pkg::FAST) // see (RULE8)
    else $error("drop terminated too early");
  a_sync_edges: assert property ($rose(break_sync) |-> st_q.tick == TW'(charge_pkg::SYNC_DELAY_T)) // see (RULE6)
    else $error("sync pulse misplaced");
  // A removal clears the timebase, so a pulse cut short by it is legal
  a_sync_end: assert property ($fell(break_sync) && !$past(sense.removed) // see (RULE6)
    |-> st_q.tick == TW'(charge_pkg::SYNC_END_T)) else $error("sync pulse wrong width");
  a_break_off: assert property (st_q.tick < TW'(charge_pkg::BREAK_T) |-> !charge_on) // see (RULE4)
    else $error("current on during break");
  a_slope_hold: assert property (st_q.mode == charge_pkg::FAST // see (RULE18)
    && st_q.stage_cyc < CW'(charge_pkg::SLOPE_HOLD_CYC) |=> st_q.mode != charge_pkg::TOPOFF)
    else $error("slope stop inside hold time");
  a_temp_fail: assert property (!sense.temp_ok && !sense.removed // see (RULE13)
    |=> st_q.mode == charge_pkg::FAILED && !charge_on) else $error("charging outside temperature window");
  a_topoff_ind: assert property (st_q.mode == charge_pkg::TOPOFF // see (RULE15)
    |-> ind.topoff_indicator && ind.trickle_indicator && !ind.fast_charge_indicator)
    else $error("top-off indicators wrong");
  a_blink_edge: assert property (st_q.mode == charge_pkg::FAST && $past(st_q.mode) == charge_pkg::FAST // see (RULE17)
    && $changed(ind.fast_charge_indicator) |-> st_q.tick[charge_pkg::BLINK_BIT-1:0] == '0)
    else $error("blink edge off the divider");
endmodule : charge_ctrl
`default_nettype wire

// *** design/charge_pkg.sv ***
package charge_pkg;
  // Timing base
  localparam int CLK_HZ = 50000000;
  localparam int OSC_HZ = 800;
  localparam int MS_PER_S = 1000;
  localparam int S_PER_MIN = 60;
  localparam int CYCLE_MS = 20480;
  localparam int BREAK_MS = 2560;
  localparam int SETTLE_MS = 1280;
  localparam int SYNC_DELAY_MS = 40;
  localparam int SYNC_WIDTH_MS = 10;
  localparam int PULSE_MS = 5120;
  localparam int TRICKLE_PERIOD_MS = 1310720;
  localparam int SLOPE_HOLD_MIN = 5;
  localparam int PREFORM_MIN = 10;
  localparam int TOPOFF_MIN = 20;
  localparam int BLINK_DIV = 1024;

  function automatic int ticks_up(input int ms);
    return (ms * OSC_HZ + MS_PER_S - 1) / MS_PER_S;
  endfunction : ticks_up

  function automatic int cycles_up(input int minutes);
    return (minutes * S_PER_MIN * MS_PER_S + CYCLE_MS - 1) / CYCLE_MS;
  endfunction : cycles_up

  localparam int OSC_DIV = CLK_HZ / OSC_HZ;
  localparam int CYCLE_T = ticks_up(CYCLE_MS);
  localparam int BREAK_T = ticks_up(BREAK_MS);
  localparam int SETTLE_T = ticks_up(SETTLE_MS);
  localparam int SYNC_DELAY_T = ticks_up(SYNC_DELAY_MS);
  localparam int SYNC_END_T = SYNC_DELAY_T + ticks_up(SYNC_WIDTH_MS);
  localparam int PULSE_END_T = BREAK_T + ticks_up(PULSE_MS);
  localparam int TRICKLE_CYC = TRICKLE_PERIOD_MS / CYCLE_MS;
  localparam int SLOPE_HOLD_CYC = cycles_up(SLOPE_HOLD_MIN);
  localparam int PREFORM_CYC = cycles_up(PREFORM_MIN);
  localparam int TOPOFF_CYC = cycles_up(TOPOFF_MIN);
  localparam int TICK_W = $clog2(CYCLE_T);
  localparam int CYC_W = $clog2(TRICKLE_CYC);
  localparam int BLINK_BIT = $clog2(BLINK_DIV) - 1;

  // Converter and termination
  localparam int COARSE_W = 5;
  localparam int FINE_W = 5;
  localparam int CODE_W = COARSE_W + FINE_W;
  localparam int STEP_UV = 6500;
  localparam int NDV_UV = 12000;
  localparam int NDV_LSB = (NDV_UV + STEP_UV - 1) / STEP_UV;
  localparam int NDV_REPEAT = 3;
  localparam int SLOPE_W = 4;
  localparam int SLOPE_HALF = 8;
  localparam int SLOPE_LIMIT = 2;

  typedef enum logic [2:0] {
    NO_BATT = 3'h0,
    PREFORM = 3'h1,
    FAST = 3'h2,
    TOPOFF = 3'h3,
    TRICKLE = 3'h4,
    FAILED = 3'h5
  } mode_e;

  typedef enum logic [1:0] {
    CONV_IDLE = 2'h0,
    CONV_COARSE = 2'h1,
    CONV_FINE = 2'h2
  } conv_e;

  // Comparator levels from the analog front end
  typedef struct packed {
    logic removed;
    logic overload;
    logic batt_low;
    logic below_preform;
    logic temp_ok;
    logic sensor_fault;
    logic dac_above;
  } sense_s;

  typedef struct packed {
    logic failure_indicator;
    logic trickle_indicator;
    logic fast_charge_indicator;
    logic topoff_indicator;
  } ind_s;
endpackage : charge_pkg

// *** design/osc_tick_gen.sv ***
`timescale 1ns/100ps
`default_nettype none
module osc_tick_gen #(
  parameter int DIV = charge_pkg::OSC_DIV
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable,
  // Oscillator tick
  output logic tick
);
  localparam int W = $clog2(DIV);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } st_s;

  st_s st_q;
  st_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (st_q.cnt == W'(DIV - 1)) begin // see (RULE22)
      st_d.cnt = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + W'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else if (enable) begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;

  a_tick_single: assert property (@(posedge clock) disable iff (!rst_n || !enable) // see (RULE22)
    st_q.tick |=> !st_q.tick) else $error("oscillator tick longer than one cycle");
endmodule : osc_tick_gen
`default_nettype wire

// *** design/slope_counter.sv ***
`timescale 1ns/100ps
`default_nettype none
module slope_counter #(
  parameter logic [charge_pkg::SLOPE_W-1:0] START = '0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable,
  // Per-measurement step
  input wire logic clear,
  input wire logic step,
  input wire logic signed [charge_pkg::SLOPE_W-1:0] delta,
  // Decision
  output logic detect
);
  localparam int W = charge_pkg::SLOPE_W;

  typedef struct packed {
    logic [W-1:0] phase;
    logic signed [W-1:0] acc;
    logic detect;
  } st_s;

  st_s st_q;
  st_s st_d;

  function automatic logic signed [W-1:0] sat(input logic signed [W:0] v);
    if (v > (W+1)'(2**(W-1) - 1)) return W'(2**(W-1) - 1);
    if (v < -(W+1)'(2**(W-1))) return W'(-(2**(W-1)));
    return v[W-1:0];
  endfunction : sat

  always_comb begin
    st_d = st_q;
    st_d.detect = 1'b0;
    if (clear) begin
      st_d.phase = START;
      st_d.acc = '0;
    end else if (step) begin // see (RULE9)
      // Up for the first half, down for the second: net is the slope change
      if (st_q.phase < W'(charge_pkg::SLOPE_HALF)) begin // see (RULE10)
        st_d.acc = sat({st_q.acc[W-1], st_q.acc} + {delta[W-1], delta});
      end else begin
        st_d.acc = sat({st_q.acc[W-1], st_q.acc} - {delta[W-1], delta});
      end
      st_d.phase = st_q.phase + W'(1);
      if (st_q.phase == W'(2 * charge_pkg::SLOPE_HALF - 1)) begin
        st_d.detect = st_d.acc > W'(charge_pkg::SLOPE_LIMIT); // see (RULE11)
        st_d.acc = '0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{phase: START, acc: '0, detect: 1'b0};
    end else if (enable) begin
      st_q <= st_d;
    end
  end

  assign detect = st_q.detect;

  a_window_end: assert property (@(posedge clock) disable iff (!rst_n || !enable) // see (RULE11)
    st_q.detect |-> st_q.phase == '0) else $error("slope decision outside window end");
endmodule : slope_counter
`default_nettype wire

// *** sim/battery_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module battery_model (
  // Pack and sensor state set by the bench
  input wire logic present,
  input wire logic temp_good,
  input wire logic probe_broken,
  input wire logic [11:0] volt_code,
  // Controller side
  input wire logic [charge_pkg::CODE_W-1:0] dac_code,
  output charge_pkg::sense_s sense
);
  // Levels in converter steps of 6.5 mV
  localparam int OVERLOAD_CODE = 616;
  localparam int PREFORM_CODE = 247;
  localparam int LOW_CODE = 16;
  localparam int PULLUP_CODE = 770;
  logic [11:0] level;

  // An empty slot is pulled up to the reset level, so it also reads as overload
  assign level = present ? volt_code : 12'(PULLUP_CODE);
  always_comb begin
    sense.removed = !present;
    sense.overload = level >= 12'(OVERLOAD_CODE);
    sense.batt_low = level < 12'(LOW_CODE);
    sense.below_preform = level < 12'(PREFORM_CODE);
    sense.temp_ok = temp_good && !probe_broken;
    sense.sensor_fault = probe_broken;
    sense.dac_above = {2'h0, dac_code} >= level;
  end
endmodule : battery_model
`default_nettype wire

// *** sim/charge_ctrl_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module charge_ctrl_tb;
  localparam int DIV = 2;
  localparam int V_NORM = 300;
  localparam int LIMIT = 80000;
  logic clock;
  logic rst_n;
  logic enable;
  logic present;
  logic temp_good;
  logic probe_broken;
  logic [11:0] volt_code;
  charge_pkg::sense_s sense;
  logic charge_on;
  logic break_sync;
  logic [charge_pkg::CODE_W-1:0] dac_code;
  charge_pkg::ind_s ind;
  int err_count;
  int samples_checked;
  int cyc;

  battery_model i_battery_model (.present(present), .temp_good(temp_good), .probe_broken(probe_broken),
    .volt_code(volt_code), .dac_code(dac_code), .sense(sense));
  charge_ctrl #(.OSC_DIV(DIV)) i_charge_ctrl (.clock(clock), .rst_n(rst_n), .enable(enable), .sense(sense),
    .charge_on(charge_on), .break_sync(break_sync), .dac_code(dac_code), .ind(ind));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  // Hang guard: the planned sequence needs well under this many clocks
  always @(posedge clock) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  function automatic logic pick(input int which);
    case (which)
      0: return charge_on;
      1: return break_sync;
      2: return ind.fast_charge_indicator;
      3: return ind.trickle_indicator;
      default: return ind.failure_indicator;
    endcase
  endfunction : pick

  // Counts clocks until the chosen output reaches the level, bounded by limit
  task automatic wait_for(input int which, input logic level, input int limit, output int n);
    n = 0;
    while (pick(which) !== level && n < limit) begin
      @(posedge clock);
      #1;
      n++;
    end
    check("output level reached", {31'h0, pick(which) === level}, 32'h1);
  endtask : wait_for

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  task automatic insert(input int code);
    present = 1'b0;
    step(4);
    check("indicators with no pack", {28'h0, ind}, 32'h0);
    check("charge with no pack", {31'h0, charge_on}, 32'h0);
    volt_code = 12'(code);
    present = 1'b1;
    step(4);
  endtask : insert

  task automatic test_fast_cycle();
    int n;
    wait_for(0, 1'b1, 4200 * DIV, n);
    check("conversion result", {22'h0, dac_code}, 32'(V_NORM - 1));
    check("fast mode others off", {28'h0, ind & 4'hd}, 32'h0);
    wait_for(0, 1'b0, 15000 * DIV, n);
    check("charge phase clocks", n, (16384 - 2048) * DIV);
    wait_for(1, 1'b1, 100, n);
    check("sync delay clocks", n, 32 * DIV);
    wait_for(1, 1'b0, 100, n);
    check("sync width clocks", n, 8 * DIV);
    wait_for(0, 1'b1, 2100 * DIV, n);
    check("break rest clocks", n, (2048 - 40) * DIV);
    wait_for(2, ~ind.fast_charge_indicator, 600 * DIV, n);
    wait_for(2, ~ind.fast_charge_indicator, 600 * DIV, n);
    check("blink half period", n, 512 * DIV);
    $display("test_fast_cycle done");
  endtask : test_fast_cycle

  // Enable low must freeze everything, the prescaler included
  task automatic test_enable_hold();
    logic [31:0] snap;
    snap = {16'h0, charge_on, break_sync, ind, dac_code};
    enable = 1'b0;
    step(1200);
    check("outputs frozen", {16'h0, charge_on, break_sync, ind, dac_code}, snap);
    enable = 1'b1;
    $display("test_enable_hold done");
  endtask : test_enable_hold

  task automatic test_temp_faults();
    int n;
    for (int k = 0; k < 2; k++) begin
      temp_good = (k != 0);
      probe_broken = (k == 1);
      step(3);
      check("charge off on bad temperature", {31'h0, charge_on}, 32'h0);
      check("only failure may show", {28'h0, ind & 4'h7}, 32'h0);
      wait_for(4, 1'b1, 600 * DIV, n);
      temp_good = 1'b1;
      probe_broken = 1'b0;
      insert(V_NORM);
    end
    $display("test_temp_faults done");
  endtask : test_temp_faults

  task automatic test_overload_low_preform();
    int n;
    insert(700);
    check("overload gives trickle", {28'h0, ind}, 32'h4);
    volt_code = 12'h005;
    wait_for(4, 1'b1, 600 * DIV, n);
    check("low sense trickle off", {31'h0, ind.trickle_indicator}, 32'h0);
    insert(200);
    check("preform charge off", {31'h0, charge_on}, 32'h0);
    check("preform fast off", {31'h0, ind.fast_charge_indicator}, 32'h0);
    wait_for(3, ~ind.trickle_indicator, 600 * DIV, n);
    wait_for(3, ~ind.trickle_indicator, 600 * DIV, n);
    check("preform blink half period", n, 512 * DIV);
    $display("test_overload_low_preform done");
  endtask : test_overload_low_preform

  initial begin
    err_count = 0;
    samples_checked = 0;
    cyc = 0;
    rst_n = 1'b0;
    enable = 1'b1;
    present = 1'b1;
    temp_good = 1'b1;
    probe_broken = 1'b0;
    volt_code = 12'(V_NORM);
    step(10);
    check("outputs in reset", {16'h0, charge_on, break_sync, ind, dac_code}, 32'h0);
    rst_n = 1'b1;
    test_fast_cycle();
    test_enable_hold();
    test_temp_faults();
    test_overload_low_preform();
    give_verdict();
  end
endmodule : charge_ctrl_tb
`default_nettype wire
